// File: include/ldc_regs.svh
// register map, field positions, reset values and frame constants of the laser driver control block
// assumes: included by package and modules by bare name
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

// ----------------------------------------
// serial frame
// ----------------------------------------
`define LDC_FRAME_LAST 4'h0F
`define LDC_HDR_LAST 4'h07
`define LDC_SYNC_W 9
`define LDC_HDR_ADDR_HI 7
`define LDC_HDR_ADDR_LO 6
`define LDC_HDR_IDX_HI 5
`define LDC_HDR_IDX_LO 1

// ----------------------------------------
// register indices (address bits 4:0)
// ----------------------------------------
`define LDC_IDX_TRANSMIT_CONTROL_REG 5'h05
`define LDC_IDX_BIAS_STEP 5'h06
`define LDC_IDX_MOD_STEP 5'h07
`define LDC_IDX_BIAS_CODE 5'h08
`define LDC_IDX_MOD_CODE 5'h09
`define LDC_IDX_MOD_LIMIT 5'h0A
`define LDC_IDX_BIAS_LIMIT 5'h0B
`define LDC_IDX_STAT1 5'h0C
`define LDC_IDX_STAT2 5'h0D
`define LDC_IDX_MODE 5'h0F
`define LDC_IDX_DEEMPH 5'h10
`define LDC_IDX_EQ 5'h11

// ----------------------------------------
// fields and keys
// ----------------------------------------
`define LDC_TRANSMIT_CONTROL_REG_EN 0
`define LDC_TRANSMIT_CONTROL_REG_POL 1
`define LDC_TRANSMIT_CONTROL_REG_DE_LO 3
`define LDC_TRANSMIT_CONTROL_REG_DE_HI 4
`define LDC_STEP_LSB 7
`define LDC_STAT1_FAULT 0
`define LDC_STAT1_SIGNAL 5
`define LDC_STAT2_BIAS 0
`define LDC_STAT2_MOD 1
`define LDC_UNLOCK_KEY 8'h12

// ----------------------------------------
// reset values
// ----------------------------------------
`define LDC_RST_CODE 8'h04
`define LDC_RST_LIMIT 8'hFF
`define LDC_RST_BYTE 8'h00
`define LDC_RST_EQ 2'h0

`endif

// File: include/ldc_pkg.sv
// types of the laser driver control block
// assumes: ldc_regs.svh on the include path
`include "ldc_regs.svh"

package ldc_pkg;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_HDR = 2'b01,
    SER_WR = 2'b10,
    SER_RD = 2'b11
  } ser_state_t;

  typedef struct packed {
    logic [`LDC_SYNC_W-1:0] s1;
    logic [`LDC_SYNC_W-1:0] s2;
  } sync_state_t;

  typedef struct packed {
    ser_state_t ser;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] hdr;
    logic [7:0] tx_shift;
    logic sda_oe;
    logic sda_out;
    logic scl_prev;
    logic sel_prev;
    logic dis_prev;
    logic unlock_pending;
    logic frame_free;
    logic [7:0] transmit_control_reg;
    logic [7:0] bias_up;
    logic bias_lsb;
    logic [7:0] bias_lim;
    logic [7:0] bias_step;
    logic [7:0] mod_up;
    logic mod_lsb;
    logic [7:0] mod_lim;
    logic [7:0] mod_step;
    logic [7:0] deemph;
    logic [1:0] eq;
    logic fault_latch;
    logic bias_flag;
    logic mod_flag;
    logic bias_en;
    logic mod_en;
  } ctrl_state_t;

endpackage

// File: src/sync_two_ff.sv
// two-flop synchroniser for every pin that arrives from outside the system clock domain
// assumes: the clock enable freezes it along with the rest of the block
`timescale 1ns/1ps
`include "ldc_regs.svh"

module sync_two_ff (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic [`LDC_SYNC_W-1:0] i_async,
  output logic [`LDC_SYNC_W-1:0] o_sync
);

  ldc_pkg::sync_state_t q;
  ldc_pkg::sync_state_t d;

  always_comb begin
    d = q;
    if (i_clk_en) begin
      d.s1 = i_async;
      d.s2 = q.s1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;

endmodule

// File: src/step_saturator.sv
// adds a signed five-bit step to an eight-bit code, clamping at zero and at a limit
// assumes: purely combinational, inputs come from registers of the caller
`timescale 1ns/1ps

module step_saturator (
  input wire logic [7:0] i_code,
  input wire logic [4:0] i_step,
  input wire logic [7:0] i_limit,
  output logic [7:0] o_code,
  output logic o_over
);

  logic signed [9:0] sum;

  always_comb begin
    sum = $signed({2'h0, i_code}) + $signed({{5{i_step[4]}}, i_step});
    o_over = 1'b0;
    if (sum < $signed(10'h000)) begin
      o_code = 8'h00;
    end else if (sum > $signed({2'h0, i_limit})) begin
      o_code = i_limit;
      o_over = 1'b1;
    end else begin
      o_code = sum[7:0];
    end
  end

endmodule

// File: src/laser_driver_control_regs.sv
// serial-programmed control register bank of a laser driver
// assumes: select, serial clock, data, disable, strap comparators, fault detector and
// signal detector are asynchronous pins; the serial clock is far slower than i_clk_sys
//
// Operation
// - a rising select line starts a new serial command
// - select going low ends the command and returns the serial machine to idle
// - strap level maps to address bits 6:5 as 11, 10, 01, 00
// - disable high or open turns bias and modulation off
// - a detected fault drives fault output high and keeps it latched
// - fault clears only when gone and latch cleared by toggling disable
// - data pin is open-drain while returning read data, else an input
// - two-bit equaliser setting selects 1, 3 or 5.5 dB boost
// - polarity bit in transmit control sets outputs following or inverting inputs
// - bit 5 of first transmit status shows AC input signal presence
// - nine-bit bias code, upper eight written directly during initialisation
// - bias code lsb cleared at reset, then set only through step bit 7
// - upper bias code never exceeds the bias limit register
// - low five step bits are a signed step added to the bias code
// - overshooting increment sets bias warning flag and loads the limit
// - modulation uses code, limit, step and deemphasis registers
// - overshooting modulation increment sets warning flag and loads its limit
// - each operation is sixteen bits, msb first, sixteen master clocks
// - in a read the device returns eight bits msb first on rising clocks
`timescale 1ns/1ps
`include "ldc_regs.svh"

module laser_driver_control_regs (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic i_select_strobe,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [2:0] i_address_strap_pin,
  input wire logic i_disable,
  input wire logic i_fault_detect,
  input wire logic i_signal_present,
  output logic o_fault,
  output logic [8:0] o_bias_dac_code,
  output logic [8:0] o_mod_dac_code,
  output logic o_bias_en,
  output logic o_mod_en,
  output logic o_output_polarity_bit,
  output logic [1:0] o_input_eq_setting,
  output logic [7:0] o_deemphasis_setting,
  output logic [1:0] o_deemphasis_ctrl
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [1:0] strap_decode(input logic [2:0] cmp);
    logic [1:0] r;
    r = 2'h0;
    case (cmp)
      3'h7: r = 2'h3;
      3'h3: r = 2'h2;
      3'h1: r = 2'h1;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? b : a;
  endfunction

  // the address is judged at the header for a read and only at the commit for a write
  function automatic logic addr_match(input logic [7:0] hdr, input logic [2:0] strap);
    return hdr[`LDC_HDR_ADDR_HI:`LDC_HDR_ADDR_LO] == strap_decode(strap);
  endfunction

  function automatic logic [4:0] hdr_index(input logic [7:0] hdr);
    return hdr[`LDC_HDR_IDX_HI:`LDC_HDR_IDX_LO];
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`LDC_SYNC_W-1:0] sync_out;
  logic scl_s;
  logic sel_s;
  logic sda_s;
  logic dis_s;
  logic flt_s;
  logic sig_s;
  logic [2:0] strap_s;

  sync_two_ff u_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_clk_en(i_clk_en),
    .i_async({i_address_strap_pin, i_signal_present, i_fault_detect, i_disable, i_sda_in, i_select_strobe, i_scl}),
    .o_sync(sync_out)
  );

  assign {strap_s, sig_s, flt_s, dis_s, sda_s, sel_s, scl_s} = sync_out;

  // ----------------------------------------
  // state
  // ----------------------------------------
  ldc_pkg::ctrl_state_t q;
  ldc_pkg::ctrl_state_t d;

  logic [7:0] wr_data;
  logic [7:0] bias_step_code;
  logic [7:0] mod_step_code;
  logic bias_over;
  logic mod_over;

  // write data as it stands at the sixteenth rising clock, before it is shifted in
  assign wr_data = {q.rx_shift[6:0], sda_s};

  step_saturator u_bias_sat (
    .i_code(q.bias_up),
    .i_step(wr_data[4:0]),
    .i_limit(q.bias_lim),
    .o_code(bias_step_code),
    .o_over(bias_over)
  );

  step_saturator u_mod_sat (
    .i_code(q.mod_up),
    .i_step(wr_data[4:0]),
    .i_limit(q.mod_lim),
    .o_code(mod_step_code),
    .o_over(mod_over)
  );

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  function automatic logic [7:0] reg_read(input ldc_pkg::ctrl_state_t s, input logic [4:0] idx,
                                          input logic sig);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      `LDC_IDX_TRANSMIT_CONTROL_REG: r = s.transmit_control_reg;
      `LDC_IDX_BIAS_STEP: r = s.bias_step;
      `LDC_IDX_MOD_STEP: r = s.mod_step;
      `LDC_IDX_BIAS_CODE: r = s.bias_up;
      `LDC_IDX_MOD_CODE: r = s.mod_up;
      `LDC_IDX_MOD_LIMIT: r = s.mod_lim;
      `LDC_IDX_BIAS_LIMIT: r = s.bias_lim;
      `LDC_IDX_STAT1: begin
        r[`LDC_STAT1_FAULT] = s.fault_latch;
        r[`LDC_STAT1_SIGNAL] = sig;
      end
      `LDC_IDX_STAT2: begin
        r[`LDC_STAT2_BIAS] = s.bias_flag;
        r[`LDC_STAT2_MOD] = s.mod_flag;
      end
      `LDC_IDX_DEEMPH: r = s.deemph;
      `LDC_IDX_EQ: r = {6'h00, s.eq};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic scl_rise;
  logic sel_rise;
  logic [4:0] idx;
  logic addr_hit;
  logic wr_ok;

  always_comb begin
    d = q;
    scl_rise = scl_s & ~q.scl_prev;
    sel_rise = sel_s & ~q.sel_prev;
    idx = hdr_index(q.hdr);
    addr_hit = addr_match(q.hdr, strap_s);
    wr_ok = 1'b0;
    // a low clock enable leaves every field, edge detectors included, as it was
    if (i_clk_en) begin
      d.scl_prev = scl_s;
      d.sel_prev = sel_s;
      d.dis_prev = dis_s;

      // serial frame machine
      if (!sel_s) begin
        d.ser = ldc_pkg::SER_IDLE;
        d.sda_oe = 1'b0;
        d.bit_cnt = 4'h0;
        d.frame_free = 1'b0;
      end else if (sel_rise) begin
        d.ser = ldc_pkg::SER_HDR;
        d.bit_cnt = 4'h0;
        d.sda_oe = 1'b0;
        d.frame_free = q.unlock_pending;
        d.unlock_pending = 1'b0;
      end else if (scl_rise) begin
        d.bit_cnt = q.bit_cnt + 4'h1;
        d.rx_shift = wr_data;
        case (q.ser)
          ldc_pkg::SER_HDR: begin
            if (q.bit_cnt == `LDC_HDR_LAST) begin
              d.hdr = wr_data;
              if (sda_s && addr_match(wr_data, strap_s)) begin
                d.ser = ldc_pkg::SER_RD;
                d.tx_shift = reg_read(q, hdr_index(wr_data), sig_s);
                d.sda_oe = ~d.tx_shift[7];
              end else if (sda_s) begin
                d.ser = ldc_pkg::SER_IDLE;
              end else begin
                d.ser = ldc_pkg::SER_WR;
              end
            end
          end
          ldc_pkg::SER_RD: begin
            d.tx_shift = {q.tx_shift[6:0], 1'b0};
            d.sda_oe = ~d.tx_shift[7];
            if (q.bit_cnt == `LDC_FRAME_LAST) begin
              d.sda_oe = 1'b0;
              d.ser = ldc_pkg::SER_IDLE;
            end
          end
          ldc_pkg::SER_WR: begin
            if (q.bit_cnt == `LDC_FRAME_LAST) begin
              d.ser = ldc_pkg::SER_IDLE;
              wr_ok = addr_hit;
            end
          end
          default: d.ser = ldc_pkg::SER_IDLE;
        endcase
      end

      // disable falling edge clears the warnings, and the fault latch only when the fault is gone
      if (q.dis_prev && !dis_s) begin
        if (!flt_s) begin
          d.fault_latch = 1'b0;
        end
        d.bias_flag = 1'b0;
        d.mod_flag = 1'b0;
      end

      // register write commit
      if (wr_ok) begin
        if (q.frame_free) begin
          case (idx)
            `LDC_IDX_TRANSMIT_CONTROL_REG: d.transmit_control_reg = wr_data;
            `LDC_IDX_BIAS_CODE: d.bias_up = min8(wr_data, q.bias_lim);
            `LDC_IDX_MOD_CODE: d.mod_up = min8(wr_data, q.mod_lim);
            `LDC_IDX_BIAS_LIMIT: begin
              d.bias_lim = wr_data;
              d.bias_up = min8(q.bias_up, wr_data);
            end
            `LDC_IDX_MOD_LIMIT: begin
              d.mod_lim = wr_data;
              d.mod_up = min8(q.mod_up, wr_data);
            end
            `LDC_IDX_DEEMPH: d.deemph = wr_data;
            `LDC_IDX_EQ: d.eq = wr_data[1:0];
            default: d.eq = q.eq;
          endcase
        end
        // step and mode registers stay writable without unlocking
        case (idx)
          `LDC_IDX_BIAS_STEP: begin
            d.bias_step = wr_data;
            d.bias_lsb = wr_data[`LDC_STEP_LSB];
            d.bias_up = bias_step_code;
            if (bias_over) begin
              d.bias_flag = 1'b1;
            end
          end
          `LDC_IDX_MOD_STEP: begin
            d.mod_step = wr_data;
            d.mod_lsb = wr_data[`LDC_STEP_LSB];
            d.mod_up = mod_step_code;
            if (mod_over) begin
              d.mod_flag = 1'b1;
            end
          end
          `LDC_IDX_MODE: begin
            if (wr_data == `LDC_UNLOCK_KEY) begin
              d.unlock_pending = 1'b1;
            end
          end
          default: d.unlock_pending = d.unlock_pending;
        endcase
      end

      // a fault present in the same cycle as the clear keeps the latch set
      if (flt_s) begin
        d.fault_latch = 1'b1;
      end

      // enables lag the control register by one clock, far below the current settling time
      d.bias_en = ~dis_s & ~d.fault_latch & q.transmit_control_reg[`LDC_TRANSMIT_CONTROL_REG_EN];
      d.mod_en = ~dis_s & ~d.fault_latch & q.transmit_control_reg[`LDC_TRANSMIT_CONTROL_REG_EN];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '0;
      q.ser <= ldc_pkg::SER_IDLE;
      q.transmit_control_reg <= `LDC_RST_BYTE;
      q.bias_up <= `LDC_RST_CODE;
      q.mod_up <= `LDC_RST_CODE;
      q.bias_lsb <= 1'b0;
      q.mod_lsb <= 1'b0;
      q.bias_lim <= `LDC_RST_LIMIT;
      q.mod_lim <= `LDC_RST_LIMIT;
      q.deemph <= `LDC_RST_BYTE;
      q.eq <= `LDC_RST_EQ;
      // matches the synchroniser's reset level, so no false disable edge follows reset
      q.dis_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: the pad only ever pulls low, the high level comes from the pull-up
  assign o_sda_out = q.sda_out;
  assign o_sda_oe = q.sda_oe;
  assign o_fault = q.fault_latch;
  assign o_bias_dac_code = {q.bias_up, q.bias_lsb};
  assign o_mod_dac_code = {q.mod_up, q.mod_lsb};
  assign o_bias_en = q.bias_en;
  assign o_mod_en = q.mod_en;
  assign o_output_polarity_bit = q.transmit_control_reg[`LDC_TRANSMIT_CONTROL_REG_POL];
  assign o_input_eq_setting = q.eq;
  assign o_deemphasis_setting = q.deemph;
  assign o_deemphasis_ctrl = q.transmit_control_reg[`LDC_TRANSMIT_CONTROL_REG_DE_HI:`LDC_TRANSMIT_CONTROL_REG_DE_LO];

endmodule

// File: dv/ldc_props.sv
// pin-level assertions for the laser driver control block
// assumes: bound to laser_driver_control_regs, one clock domain, serial pins far slower than the clock
`timescale 1ns/1ps

module ldc_props (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic i_select_strobe,
  input wire logic i_scl,
  input wire logic i_disable,
  input wire logic i_fault_detect,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_fault,
  input wire logic [8:0] o_bias_dac_code,
  input wire logic [8:0] o_mod_dac_code,
  input wire logic o_bias_en,
  input wire logic o_mod_en,
  input wire logic o_output_polarity_bit,
  input wire logic [1:0] o_input_eq_setting,
  input wire logic [7:0] o_deemphasis_setting,
  input wire logic [1:0] o_deemphasis_ctrl
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // a frozen clock enable stops all state, so nothing is judged then
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst || !i_clk_en);

  a_sda_open_drain: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data pin driven high");
  a_abort_release: assert property (!i_select_strobe [*5] |-> !o_sda_oe)
    else $error("data pin held after select low");
  a_oe_on_rise: assert property ($changed(o_sda_oe) && i_select_strobe |-> $past(i_scl, 2))
    else $error("read bit changed away from a clock rise");
  a_disable_off: assert property (i_disable [*5] |-> !o_bias_en && !o_mod_en)
    else $error("currents on while disabled");
  a_fault_sets: assert property (i_fault_detect [*5] |-> o_fault)
    else $error("fault not reported");
  a_fault_latched: assert property ((o_fault && !i_disable) [*4] |=> o_fault)
    else $error("fault cleared without disable toggle");
  a_fault_cuts: assert property (o_fault [*2] |-> !o_bias_en && !o_mod_en)
    else $error("currents on during fault");
  a_codes_idle: assert property (!i_select_strobe [*6] |=> $stable(o_bias_dac_code) && $stable(o_mod_dac_code))
    else $error("code changed outside a command");
  a_setting_idle: assert property (!i_select_strobe [*6] |=>
    $stable({o_output_polarity_bit, o_input_eq_setting, o_deemphasis_setting, o_deemphasis_ctrl}))
    else $error("setting changed outside a command");
endmodule

bind laser_driver_control_regs ldc_props chk_u (.i_clk_sys, .i_srst, .i_clk_en, .i_select_strobe, .i_scl,
  .i_disable, .i_fault_detect, .o_sda_out, .o_sda_oe, .o_fault, .o_bias_dac_code, .o_mod_dac_code,
  .o_bias_en, .o_mod_en, .o_output_polarity_bit, .o_input_eq_setting, .o_deemphasis_setting,
  .o_deemphasis_ctrl);

// File: dv/serial_master_model.sv
// behavioural serial bus master: select, 800 ns serial clock, open-drain data
// assumes: the bench resolves the data wire with a pull-up and feeds it back here
`timescale 1ns/1ps

module serial_master_model (
  input wire logic i_clk_sys,
  input wire logic i_sda_wire,
  output logic o_select,
  output logic o_scl,
  output logic o_sda_low
);
  // ----------------------------------------
  // frame task
  // ----------------------------------------
  initial begin
    o_select <= 1'b0;
    o_scl <= 1'b0;
    o_sda_low <= 1'b0;
  end

  // nbits below 16 cuts the frame short, so an abort can be provoked
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
    int k;
    rd = 8'h00;
    @(posedge i_clk_sys);
    o_select <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    for (k = 0; k < nbits; k++) begin
      o_scl <= 1'b0;
      // msb first; data line let go after the direction bit of a read
      o_sda_low <= (k < 8 || !frame[8]) ? !frame[15 - k] : 1'b0;
      repeat (4) @(posedge i_clk_sys);
      // the device answers three clocks after a rise, so the bit has settled here
      if (frame[8] && k >= 8) rd = {rd[6:0], i_sda_wire};
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
    end
    o_scl <= 1'b0;
    o_sda_low <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    o_select <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
  endtask
endmodule

// File: dv/testbench.sv
// self-checking bench of the laser driver control block against an integer model
// assumes: ldc_regs.svh on the include path; checker bound from its own file
`timescale 1ns/1ps
`include "ldc_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic dis = 1'b0;
  logic fdet = 1'b0;
  logic sig = 1'b0;
  logic [2:0] strap = 3'h7;
  logic [1:0] adr = 2'h3;
  logic sel, scl, sda_low, oe, sdo, fault, ben, men, pol;
  logic [8:0] bcode, mcode;
  logic [1:0] eq, dctl;
  logic [7:0] de, rd;
  wire sda = !(sda_low || (oe && !sdo));
  int fail_count = 0;
  int tests_run = 0;
  int seed = 3;
  int m_b = 4, m_m = 4, m_bl = 255, m_ml = 255, m_bs = 0, m_ms = 0;
  bit m_bf, m_mf;

  always #50 clk = ~clk;

  laser_driver_control_regs dut_u (.i_clk_sys(clk), .i_srst(srst), .i_clk_en(clk_en), .i_select_strobe(sel),
    .i_scl(scl), .i_sda_in(sda), .o_sda_out(sdo), .o_sda_oe(oe), .i_address_strap_pin(strap),
    .i_disable(dis), .i_fault_detect(fdet), .i_signal_present(sig), .o_fault(fault),
    .o_bias_dac_code(bcode), .o_mod_dac_code(mcode), .o_bias_en(ben), .o_mod_en(men),
    .o_output_polarity_bit(pol), .o_input_eq_setting(eq), .o_deemphasis_setting(de),
    .o_deemphasis_ctrl(dctl));
  serial_master_model m_u (.i_clk_sys(clk), .i_sda_wire(sda), .o_select(sel), .o_scl(scl), .o_sda_low(sda_low));

  // ----------------------------------------
  // tasks and model
  // ----------------------------------------
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    m_u.xfer({adr, idx, 1'b0, d}, 16, rd);
  endtask
  task automatic rdv(input logic [4:0] idx);
    m_u.xfer({adr, idx, 1'b1, 8'h00}, 16, rd);
  endtask
  task automatic setup(input logic [4:0] idx, input logic [7:0] d);
    wr(`LDC_IDX_MODE, `LDC_UNLOCK_KEY);
    wr(idx, d);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic cmp_codes();
    `CHK(bcode, 9'(m_b * 2 + m_bs))
    `CHK(mcode, 9'(m_m * 2 + m_ms))
  endtask
  function automatic int stepped(input int c, input logic [7:0] b, input int lim, output bit ov);
    int v;
    v = c + int'($signed(b[4:0]));
    ov = v > lim;
    v = (v < 0) ? 0 : v;
    return ov ? lim : v;
  endfunction
  task automatic step(input bit is_mod, input logic [7:0] b);
    bit ov;
    wr(is_mod ? `LDC_IDX_MOD_STEP : `LDC_IDX_BIAS_STEP, b);
    if (is_mod) begin
      m_m = stepped(m_m, b, m_ml, ov);
      m_ms = b[`LDC_STEP_LSB];
      m_mf |= ov;
    end else begin
      m_b = stepped(m_b, b, m_bl, ov);
      m_bs = b[`LDC_STEP_LSB];
      m_bf |= ov;
    end
    cmp_codes();
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_codes();
    `CHK({fault, ben, men, pol}, 4'h0)
    done("reset");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      strap <= 3'((1 << i) - 1);
      adr = 2'(i);
      repeat (4) @(posedge clk);
      rdv(`LDC_IDX_STAT2);
      `CHK(rd, 8'h00)
      adr = 2'(i + 1);
      rdv(`LDC_IDX_STAT2);
      `CHK(rd, 8'hFF)
      adr = 2'(i);
    end
    rdv(`LDC_IDX_BIAS_LIMIT);
    `CHK(rd, `LDC_RST_LIMIT)
    rdv(5'h1F);
    `CHK(rd, 8'h00)
    done("strap");
    wr(`LDC_IDX_BIAS_CODE, 8'h77);
    `CHK(bcode, 9'(m_b * 2))
    setup(`LDC_IDX_BIAS_LIMIT, 8'h30);
    setup(`LDC_IDX_MOD_LIMIT, 8'h28);
    setup(`LDC_IDX_BIAS_CODE, 8'h50);
    setup(`LDC_IDX_MOD_CODE, 8'h02);
    wr(`LDC_IDX_BIAS_CODE, 8'h10);
    m_bl = 'h30;
    m_ml = 'h28;
    m_b = 'h30;
    m_m = 2;
    cmp_codes();
    step(1'b1, 8'h10);
    step(1'b0, 8'h8F);
    for (int i = 0; i < 20; i++) step(1'(i), 8'($random(seed)));
    rdv(`LDC_IDX_STAT2);
    `CHK(rd, {6'h00, m_mf, m_bf})
    m_u.xfer({adr, `LDC_IDX_BIAS_STEP, 1'b0, 8'h81}, 12, rd);
    cmp_codes();
    // a read cut after four data bits, aborted while the device may pull the line
    m_u.xfer({adr, `LDC_IDX_BIAS_LIMIT, 1'b1, 8'h00}, 12, rd);
    `CHK(rd, 8'(m_bl >> 4))
    `CHK(oe, 1'b0)
    step(1'b0, 8'h01);
    done("steps");
    setup(5'h05, 8'h1B);
    `CHK({ben, men, pol, dctl}, 5'h1F)
    for (int c = 0; c < 4; c++) begin
      setup(`LDC_IDX_EQ, 8'(c));
      `CHK(eq, 2'(c))
    end
    setup(`LDC_IDX_DEEMPH, 8'hA5);
    `CHK(de, 8'hA5)
    // a low clock enable must hold both current enables on, even against a raised disable
    @(posedge clk);
    clk_en <= 1'b0;
    dis <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({ben, men}, 2'b11)
    clk_en <= 1'b1;
    done("settings");
    @(posedge clk);
    dis <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({ben, men}, 2'b00)
    dis <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({ben, men}, 2'b11)
    rdv(`LDC_IDX_STAT2);
    `CHK(rd, 8'h00)
    @(posedge clk);
    sig <= 1'b1;
    fdet <= 1'b1;
    repeat (8) @(posedge clk);
    // toggling disable while the fault persists must not clear the latch
    dis <= 1'b1;
    repeat (8) @(posedge clk);
    dis <= 1'b0;
    repeat (8) @(posedge clk);
    fdet <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({fault, ben}, 2'b10)
    rdv(`LDC_IDX_STAT1);
    `CHK(rd, 8'h21)
    @(posedge clk);
    dis <= 1'b1;
    repeat (45) @(posedge clk);
    dis <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({fault, ben}, 2'b01)
    done("fault");
    final_report();
  end

  initial begin
    #4000000;
    fail_count++;
    final_report();
  end
endmodule
